/* File: rtl/tally_defs.svh */
// tally_defs.svh: offsets, field positions, reset values and sizes for the
// sample-derived event tally.
// assumes: included by bare name; holds definitions only.
`ifndef TALLY_DEFS_SVH
`define TALLY_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define TALLY_NUM_EVENTS 40
`define TALLY_NUM_SUMS 3
`define TALLY_LAT_W 16
`define TALLY_SRC_W 3

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TALLY_CNT_BASE 12'h000
`define TALLY_SUM_BASE 12'h0A0
`define TALLY_CTRL_OFS 12'h0C0
`define TALLY_SEEN_OFS 12'h0C4
`define TALLY_ADDR_W 12

// ----------------------------------------------------------------
// control fields and reset value
// ----------------------------------------------------------------
`define TALLY_CTRL_EN_BIT 0
`define TALLY_CTRL_CLR_BIT 1
`define TALLY_CTRL_RESET 1'h0

// ----------------------------------------------------------------
// request-source codes
// ----------------------------------------------------------------
`define TALLY_NB_VALID_SRC 3'h0
`define TALLY_SRC_L3 3'h1
`define TALLY_SRC_CACHE 3'h2
`define TALLY_SRC_DRAM 3'h3
`define TALLY_SRC_OTHER 3'h7

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define TALLY_RESP_OKAY 2'h0
`define TALLY_RESP_SLVERR 2'h2

`endif

/* File: rtl/tally_pkg.sv */
// tally_pkg.sv: types for the sample-derived event tally.
// assumes: tally_defs.svh is on the include path.
`include "tally_defs.svh"

package tally_pkg;

  typedef logic [31:0] word_t;

  // one retired-op sample record
  typedef struct packed {
    logic op_is_branch;
    logic branch_mispredicted;
    logic branch_taken;
    logic op_is_return;
    logic return_mispredicted;
    logic op_is_resync;
    logic op_is_load;
    logic op_is_store;
    logic l1_dtlb_missed;
    logic l2_dtlb_missed;
    logic linear_address_valid;
    logic dcache_missed;
    logic misaligned_access;
    logic load_bank_conflict;
    logic store_bank_conflict;
    logic store_load_forwarded;
    logic store_load_forward_cancelled;
    logic uncacheable_access;
    logic write_combining_access;
    logic locked_op;
    logic miss_buffer_hit;
    logic l1_dtlb_hit_2m_page;
    logic l1_dtlb_hit_1g_page;
    logic l2_dtlb_hit_2m_page;
    logic [`TALLY_LAT_W-1:0] dcache_miss_latency;
    logic [`TALLY_SRC_W-1:0] nb_request_source;
    logic nb_remote_destination;
    logic nb_cache_hit_owned_state;
  } sample_s;

endpackage

/* File: rtl/sample_derived_event_tally.sv */
// sample_derived_event_tally.sv: classifies retired-op sample records into
// derived events and keeps one counter per event plus three latency sums.
// assumes: samples come from logic on aclk; registers reached over AXI4-Lite.
//
// Behaviour
// - branch sample counts branch, mispredicted, taken, mispredicted-taken events.
// - return flag counts return, plus mispredicted return; resync flag counts resync.
// - branch/return/resync flags are trusted to mark architectural branches only.
// - load or store counts load/store; load and store counted separately.
// - other data-side events need load or store flag set.
// - L1 DTLB hit: L1 miss clear and linear address valid.
// - L1 miss with L2 hit; double miss when both miss flags set.
// - dcache miss, dcache hit when clear, misaligned access.
// - load bank conflict and store bank conflict each from own flag.
// - store-to-load forwarded and forwarding-cancelled each from own flag.
// - uncacheable, write-combining, locked, miss-buffer-hit each from own flag.
// - streaming stores to write-back memory arrive flagged write-combining.
// - L1 page size 4K, 2M or 1G only with linear address valid.
// - L2 page size 4K or 2M when L1 miss, L2 hit, address valid.
// - L1 page-size flags always reflect the completed translation.
// - miss latency summed only when load and dcache miss both set.
// - northbridge events need load, dcache miss and source compared with zero.
// - valid northbridge sample counts local or remote by destination flag.
// - source 1 local counts L3; source 2 counts inter-core or remote cache.
// - source 3 counts DRAM, source 7 other, split local and remote.
// - source 2 counts Modified or Owned hit by hit-state flag.
// - miss latency summed locally or remotely by destination flag.
`timescale 1ns/100ps
`include "tally_defs.svh"

module sample_derived_event_tally (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_valid,
  input wire tally_pkg::sample_s sample,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output tally_pkg::word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic tally_pkg::word_t accumulate(tally_pkg::word_t v, logic clr,
                                                  tally_pkg::word_t amt);
    accumulate = (clr ? 32'h0000_0000 : v) + amt;
  endfunction

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  logic enable_r;
  logic clear_r;
  tally_pkg::word_t seen_r;
  // samples offered while enable is low are dropped, not queued
  wire logic take = sample_valid & enable_r;
  tally_pkg::sample_s s;
  assign s = sample;

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  // flags are used as delivered; the source keeps microcode branches,
  // streaming-store and page-size marking correct
  logic [`TALLY_NUM_EVENTS-1:0] hit;
  wire logic mem_op = s.op_is_load | s.op_is_store;
  wire logic lin_ok = mem_op & s.linear_address_valid;
  wire logic l2_ok = lin_ok & s.l1_dtlb_missed & ~s.l2_dtlb_missed;
  wire logic miss_ld = s.op_is_load & s.dcache_missed;
  // validity compare kept exactly as printed
  wire logic nb_ok = miss_ld & (s.nb_request_source == `TALLY_NB_VALID_SRC);
  wire logic loc = nb_ok & ~s.nb_remote_destination;
  wire logic rem = nb_ok & s.nb_remote_destination;
  wire logic src_l3 = s.nb_request_source == `TALLY_SRC_L3;
  wire logic src_cache = s.nb_request_source == `TALLY_SRC_CACHE;
  wire logic src_dram = s.nb_request_source == `TALLY_SRC_DRAM;
  wire logic src_other = s.nb_request_source == `TALLY_SRC_OTHER;

  // branch group, counters 0..6
  assign hit[0] = s.op_is_branch;
  assign hit[1] = s.op_is_branch & s.branch_mispredicted;
  assign hit[2] = s.op_is_branch & s.branch_taken;
  assign hit[3] = s.op_is_branch & s.branch_taken & s.branch_mispredicted;
  assign hit[4] = s.op_is_return;
  assign hit[5] = s.op_is_return & s.return_mispredicted;
  assign hit[6] = s.op_is_resync;

  // every data-side event is gated by mem_op, so a stray flag on a
  // non-memory op never counts
  // load/store group, counters 7..26
  assign hit[7] = mem_op;
  assign hit[8] = s.op_is_load;
  assign hit[9] = s.op_is_store;
  assign hit[10] = lin_ok & ~s.l1_dtlb_missed;
  assign hit[11] = mem_op & s.l1_dtlb_missed & ~s.l2_dtlb_missed;
  assign hit[12] = mem_op & s.l1_dtlb_missed & s.l2_dtlb_missed;
  assign hit[13] = mem_op & s.dcache_missed;
  assign hit[14] = mem_op & ~s.dcache_missed;
  assign hit[15] = mem_op & s.misaligned_access;
  assign hit[16] = mem_op & s.load_bank_conflict;
  assign hit[17] = mem_op & s.store_bank_conflict;
  assign hit[18] = mem_op & s.store_load_forwarded;
  assign hit[19] = mem_op & s.store_load_forward_cancelled;
  assign hit[20] = mem_op & s.uncacheable_access;
  assign hit[21] = mem_op & s.write_combining_access;
  assign hit[22] = mem_op & s.locked_op;
  assign hit[23] = mem_op & s.miss_buffer_hit;
  assign hit[24] = lin_ok & ~s.l1_dtlb_hit_2m_page & ~s.l1_dtlb_hit_1g_page;
  assign hit[25] = lin_ok & s.l1_dtlb_hit_2m_page;
  assign hit[26] = lin_ok & s.l1_dtlb_hit_1g_page;

  // reserved identifiers between groups get no counter at all
  assign hit[27] = l2_ok & ~s.l2_dtlb_hit_2m_page;
  assign hit[28] = l2_ok & s.l2_dtlb_hit_2m_page;

  // with the validity compare as printed only source 0 passes, so the
  // per-source counters 31..39 stay at zero; they are kept so that a
  // change of the compare needs no change of the map
  // northbridge group, counters 29..39
  assign hit[29] = loc;
  assign hit[30] = rem;
  assign hit[31] = loc & src_l3;
  assign hit[32] = loc & src_cache;
  assign hit[33] = rem & src_cache;
  assign hit[34] = loc & src_dram;
  assign hit[35] = rem & src_dram;
  assign hit[36] = loc & src_other;
  assign hit[37] = rem & src_other;
  assign hit[38] = nb_ok & src_cache & ~s.nb_cache_hit_owned_state;
  assign hit[39] = nb_ok & src_cache & s.nb_cache_hit_owned_state;

  // latency zero-extended; sums wrap silently at 2^32
  wire tally_pkg::word_t lat = {16'h0000, s.dcache_miss_latency};
  wire tally_pkg::word_t add_all = (take & miss_ld) ? lat : 32'h0000_0000;
  wire tally_pkg::word_t add_loc = (take & loc) ? lat : 32'h0000_0000;
  wire tally_pkg::word_t add_rem = (take & rem) ? lat : 32'h0000_0000;

  // ----------------------------------------------------------------
  // counters and sums
  // ----------------------------------------------------------------
  // one take strobe for all counters, so a sample never lands in
  // some counters and misses others
  // a clear in the same cycle as a hit leaves the hit counted
  tally_pkg::word_t cnt_r [0:`TALLY_NUM_EVENTS-1];
  tally_pkg::word_t sum_r [0:`TALLY_NUM_SUMS-1];

  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < `TALLY_NUM_EVENTS; i++)
    begin
      if (!aresetn)
        cnt_r[i] <= 32'h0000_0000;
      else
        cnt_r[i] <= accumulate(cnt_r[i], clear_r, {31'h0, take & hit[i]});
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sum_r[0] <= 32'h0000_0000;
      sum_r[1] <= 32'h0000_0000;
      sum_r[2] <= 32'h0000_0000;
      seen_r <= 32'h0000_0000;
    end
    else
    begin
      sum_r[0] <= accumulate(sum_r[0], clear_r, add_all);
      sum_r[1] <= accumulate(sum_r[1], clear_r, add_loc);
      sum_r[2] <= accumulate(sum_r[2], clear_r, add_rem);
      seen_r <= accumulate(seen_r, clear_r, {31'h0, take});
    end
  end

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // one 32-bit word per register; only address bits 11:0 decoded,
  // so the map repeats every 4 KB
  //   0x000 + 4*i  event counter i, i = 0..39, writes ignored
  //   0x0A0  miss latency sum, loads with a dcache miss
  //   0x0A4  northbridge local latency sum
  //   0x0A8  northbridge remote latency sum
  //   0x0C0  control: bit 0 enable, bit 1 clear-all pulse
  //   0x0C4  accepted sample count
  // anything else answers SLVERR; such reads return zero
  //
  // counter index to event
  //   0 branch, 1 mispredicted
  //   2 taken, 3 mispredicted taken
  //   4 return, 5 mispredicted return
  //   6 resync
  //   7 load or store, 8 load, 9 store
  //   10 l1 dtlb hit
  //   11 l1 miss l2 hit, 12 l1 and l2 miss
  //   13 dcache miss, 14 dcache hit
  //   15 misaligned
  //   16 load bank conflict
  //   17 store bank conflict
  //   18 store-load forwarded
  //   19 forwarding cancelled
  //   20 uncacheable, 21 write-combining
  //   22 locked, 23 miss buffer hit
  //   24..26 l1 page 4k, 2m, 1g
  //   27..28 l2 page 4k, 2m
  //   29 nb local, 30 nb remote
  //   31 local l3, 32 local inter-core
  //   33 remote cache
  //   34..35 dram local, remote
  //   36..37 other local, remote
  //   38 modified hit, 39 owned hit
  //
  // counters wrap at 2^32; software works on differences

  // ----------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------
  logic aw_full_r;
  logic w_full_r;
  logic [`TALLY_ADDR_W-1:0] aw_addr_r;
  tally_pkg::word_t w_data_r;
  logic w_strb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready = ~w_full_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // address and data may come in either order; once both are held,
  // wr_go fires for one cycle and bvalid follows at the next edge;
  // the full holders stall a second write until then
  wire logic wr_go = aw_full_r & w_full_r & ~bvalid_r;
  wire logic wr_word = aw_addr_r[1:0] == 2'h0;
  wire logic wr_cnt = wr_word && aw_addr_r < (`TALLY_SUM_BASE + 12'h00C);
  wire logic wr_ctrl = aw_addr_r == `TALLY_CTRL_OFS;
  wire logic wr_seen = aw_addr_r == `TALLY_SEEN_OFS;
  // counter registers accept writes but ignore them
  wire logic wr_ok = wr_cnt | wr_ctrl | wr_seen;
  wire logic ctrl_we = wr_go & wr_ctrl & w_strb0_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `TALLY_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & ~aw_full_r)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[`TALLY_ADDR_W-1:0];
      end
      else if (wr_go)
        aw_full_r <= 1'b0;
      if (s_axi_wvalid & ~w_full_r)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end
      else if (wr_go)
        w_full_r <= 1'b0;
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `TALLY_RESP_OKAY : `TALLY_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // enable steers counting; clear is a self-clearing pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_r <= `TALLY_CTRL_RESET;
      clear_r <= 1'b0;
    end
    else
    begin
      if (ctrl_we)
        enable_r <= w_data_r[`TALLY_CTRL_EN_BIT];
      clear_r <= ctrl_we & w_data_r[`TALLY_CTRL_CLR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------
  logic rvalid_r;
  tally_pkg::word_t rdata_r;
  logic [1:0] rresp_r;

  // data captured at the address edge, so a counter moving while
  // rvalid waits for rready cannot tear the answer
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  wire logic [`TALLY_ADDR_W-1:0] ra = s_axi_araddr[`TALLY_ADDR_W-1:0];
  wire logic ra_word = ra[1:0] == 2'h0;
  wire logic [9:0] ra_idx = ra[11:2];
  wire logic ra_cnt = ra_word && ra < `TALLY_SUM_BASE;
  wire logic ra_sum = ra_word && ra >= `TALLY_SUM_BASE && ra < (`TALLY_SUM_BASE + 12'h00C);
  wire logic [1:0] sum_idx = 2'((ra - `TALLY_SUM_BASE) >> 2);
  wire logic ra_ctrl = ra == `TALLY_CTRL_OFS;
  wire logic ra_seen = ra == `TALLY_SEEN_OFS;
  wire logic ra_ok = ra_cnt | ra_sum | ra_ctrl | ra_seen;
  wire tally_pkg::word_t ra_data =
    ra_cnt ? cnt_r[ra_idx[5:0]] :
    ra_sum ? sum_r[sum_idx] :
    ra_ctrl ? {31'h0, enable_r} :
    ra_seen ? seen_r : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `TALLY_RESP_OKAY;
    end
    else if (s_axi_arvalid & ~rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= ra_data;
      rresp_r <= ra_ok ? `TALLY_RESP_OKAY : `TALLY_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

endmodule

/* File: verif/tally_properties.sv */
// tally_properties.sv: bus-side assertions for the sample-derived event tally.
// assumes: bound to sample_derived_event_tally; one clock, sync active-low reset.
`timescale 1ns/100ps
`include "tally_defs.svh"

module tally_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire tally_pkg::word_t s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // handshake timing
  // ----------------------------------------------------------------
  reset_idle_a: assert property (disable iff (1'b0)
    !aresetn |=> s_axi_awready && s_axi_wready && !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus not idle after reset");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before taken");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles after take");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer changed before taken");
  wr_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == `TALLY_RESP_SLVERR |->
    s_axi_rdata == 32'h0)
    else $error("error read returned nonzero data");

  cover property (s_axi_rvalid && s_axi_rresp == `TALLY_RESP_SLVERR);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `TALLY_RESP_OKAY);
  cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
endmodule

bind sample_derived_event_tally tally_properties u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

/* File: verif/sample_source.sv */
// sample_source.sv: stand-in for the op-sampling hardware, one record a call.
// assumes: callers enter its tasks just after a rising edge of aclk.
`timescale 1ns/100ps

module sample_source (
  input wire logic aclk,
  output logic sample_valid,
  output tally_pkg::sample_s sample
);
  initial
  begin
    sample_valid = 1'b0;
    sample = '0;
  end

  // records mark architectural branches only and carry the final l1 page size
  task automatic send(input tally_pkg::sample_s s);
    sample_valid <= 1'b1;
    sample <= s;
    @(posedge aclk);
  endtask

  // no record offered: inverse of the last one, so a stale value never passes
  task automatic idle();
    sample_valid <= 1'b0;
    sample <= ~sample;
  endtask
endmodule

/* File: verif/testbench.sv */
// testbench.sv: self-checking bench for the sample-derived event tally.
// assumes: tally_properties bound to the design; sample_source as far side.
`timescale 1ns/100ps
`include "tally_defs.svh"

module testbench;
  localparam int LIMIT = 20000;
  logic aclk, aresetn, en;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  logic sample_valid;
  tally_pkg::sample_s sample;
  tally_pkg::word_t s_axi_rdata, exp_seen;
  tally_pkg::word_t exp_cnt [40];
  tally_pkg::word_t exp_sum [3];
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  sample_derived_event_tally dut (
    .aclk, .aresetn, .sample_valid, .sample, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  sample_source src (.aclk, .sample_valid, .sample);

  always #12.5 aclk = ~aclk;

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // bus cycles, reference model, compares
  // ----------------------------------------------------------------
  task automatic cmp(input tally_pkg::word_t got, input tally_pkg::word_t exp);
    n_compared++;
    if (got !== exp)
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp)
      err_count++;
  endtask

  task automatic final_report();
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input tally_pkg::word_t d, output logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, output tally_pkg::word_t d, output logic [1:0] r);
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic model(input tally_pkg::sample_s s);
    logic b, ld, ls, m1, m2, av, dm, nb, rm, ow;
    logic [2:0] q;
    logic [39:0] h;
    b = s.op_is_branch;
    ld = s.op_is_load;
    ls = ld | s.op_is_store;
    m1 = s.l1_dtlb_missed;
    m2 = s.l2_dtlb_missed;
    av = s.linear_address_valid;
    dm = s.dcache_missed;
    q = s.nb_request_source;
    rm = s.nb_remote_destination;
    ow = s.nb_cache_hit_owned_state;
    nb = ld & dm & (q == 3'h0);
    h = {nb & q == 3'h2 & ow, nb & q == 3'h2 & ~ow, nb & q == 3'h7 & rm,
      nb & q == 3'h7 & ~rm, nb & q == 3'h3 & rm, nb & q == 3'h3 & ~rm,
      nb & q == 3'h2 & rm, nb & q == 3'h2 & ~rm, nb & q == 3'h1 & ~rm, nb & rm, nb & ~rm,
      ls & m1 & ~m2 & s.l2_dtlb_hit_2m_page & av, ls & m1 & ~m2 & ~s.l2_dtlb_hit_2m_page & av,
      ls & s.l1_dtlb_hit_1g_page & av, ls & s.l1_dtlb_hit_2m_page & av,
      ls & ~s.l1_dtlb_hit_2m_page & ~s.l1_dtlb_hit_1g_page & av,
      ls & s.miss_buffer_hit, ls & s.locked_op, ls & s.write_combining_access,
      ls & s.uncacheable_access, ls & s.store_load_forward_cancelled,
      ls & s.store_load_forwarded, ls & s.store_bank_conflict, ls & s.load_bank_conflict,
      ls & s.misaligned_access, ls & ~dm, ls & dm, ls & m1 & m2, ls & m1 & ~m2,
      ls & ~m1 & av, s.op_is_store, ld, ls, s.op_is_resync,
      s.op_is_return & s.return_mispredicted, s.op_is_return,
      b & s.branch_taken & s.branch_mispredicted, b & s.branch_taken,
      b & s.branch_mispredicted, b};
    for (int i = 0; i < 40; i++)
      exp_cnt[i] += 32'(h[i]);
    exp_sum[0] += (ld & dm) ? 32'(s.dcache_miss_latency) : 32'h0;
    exp_sum[1] += (nb & ~rm) ? 32'(s.dcache_miss_latency) : 32'h0;
    exp_sum[2] += (nb & rm) ? 32'(s.dcache_miss_latency) : 32'h0;
    exp_seen++;
  endtask

  task automatic go(input logic [23:0] f, input logic [15:0] l, input logic [2:0] q,
      input logic [1:0] dh);
    src.send({f, l, q, dh});
    if (en)
      model({f, l, q, dh});
  endtask

  task automatic check_all();
    tally_pkg::word_t d;
    logic [1:0] r;
    for (int i = 0; i < 43; i++)
    begin
      rd(12'(4 * i), d, r);
      cmp(d, (i < 40) ? exp_cnt[i] : exp_sum[i - 40]);
      cmp(32'(r), 32'(`TALLY_RESP_OKAY));
    end
    rd(`TALLY_SEEN_OFS, d, r);
    cmp(d, exp_seen);
    cmp(32'(r), 32'(`TALLY_RESP_OKAY));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_after_reset();
    tally_pkg::word_t d;
    logic [1:0] r;
    exp_cnt = '{default: 32'h0};
    exp_sum = '{default: 32'h0};
    exp_seen = 32'h0;
    en = 1'b0;
    rd(`TALLY_CTRL_OFS, d, r);
    cmp(d, 32'h0);
    go(24'hE00000, 16'h0, 3'h0, 2'h0);
    src.idle();
    check_all();
    wr(`TALLY_CTRL_OFS, 32'h1, r);
    cmp(32'(r), 32'(`TALLY_RESP_OKAY));
    en = 1'b1;
  endtask

  task automatic t_bus();
    tally_pkg::word_t d;
    logic [1:0] r;
    rd(12'h0C8, d, r);
    cmp(d, 32'h0);
    cmp(32'(r), 32'(`TALLY_RESP_SLVERR));
    wr(12'h0C2, 32'h3, r);
    cmp(32'(r), 32'(`TALLY_RESP_SLVERR));
    wr(12'h000, 32'hFFFFFFFF, r);
    cmp(32'(r), 32'(`TALLY_RESP_OKAY));
  endtask

  task automatic t_branch();
    logic [23:0] f [8] = '{24'h800000, 24'hC00000, 24'hA00000, 24'hE00000, 24'h600000,
      24'h100000, 24'h180000, 24'h040000};
    foreach (f[i])
      go(f[i], 16'h0, 3'h0, 2'h0);
    src.idle();
    check_all();
  endtask

  task automatic t_ldst();
    logic [23:0] f [8] = '{24'h022000, 24'h01A005, 24'h02D800, 24'h0127FA, 24'h00FFFF,
      24'h02A000, 24'h010004, 24'h010020};
    foreach (f[i])
      go(f[i], 16'h0, 3'h0, 2'h0);
    src.idle();
    check_all();
  endtask

  task automatic t_northbridge();
    go(24'h021000, 16'h0123, 3'h0, 2'h0);
    go(24'h021000, 16'hFFFF, 3'h0, 2'h2);
    go(24'h021000, 16'h0040, 3'h2, 2'h3);
    go(24'h021000, 16'h0007, 3'h3, 2'h0);
    go(24'h021000, 16'h0011, 3'h7, 2'h2);
    go(24'h021000, 16'h0005, 3'h1, 2'h0);
    go(24'h011000, 16'h0100, 3'h0, 2'h0);
    go(24'h020000, 16'h0200, 3'h0, 2'h2);
    src.idle();
    check_all();
  endtask

  task automatic t_clear();
    tally_pkg::word_t d;
    logic [1:0] r;
    wr(`TALLY_CTRL_OFS, 32'h3, r);
    cmp(32'(r), 32'(`TALLY_RESP_OKAY));
    rd(`TALLY_CTRL_OFS, d, r);
    cmp(d, 32'h1);
    exp_cnt = '{default: 32'h0};
    exp_sum = '{default: 32'h0};
    exp_seen = 32'h0;
    check_all();
  endtask

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_after_reset();
    t_bus();
    t_branch();
    t_ldst();
    t_northbridge();
    t_clear();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_after_reset();
    final_report();
  end
endmodule
